// ### inc/clock_mode_map.svh
`ifndef CLOCK_MODE_MAP_SVH
`define CLOCK_MODE_MAP_SVH

// Register index on the plain register port.
`define CTRL_ONE_ADDR 4'h0
`define STATUS_ADDR 4'h1
`define LOCK_CFG_ADDR 4'h2

// Field positions of the first control register.
`define GAIN_SEL_BIT 7
`define RANGE_BIT 6
`define REF_SEL_BIT 5
`define MODE_SEL_HI 4
`define MODE_SEL_LO 3
`define KEEP_OSC_BIT 2
`define LOC_DIS_BIT 1

// Field positions of the status register.
`define MODE_ST_HI 7
`define MODE_ST_LO 6
`define REF_ST_BIT 5
`define LOCK_ST_BIT 3

// Reset values.
`define CTRL_ONE_RESET 8'h00
`define LOCK_CFG_RESET 4'h0

// Loop prescale factors for the two ranges.
`define PRESCALE_LOW 7'h40
`define PRESCALE_HIGH 7'h01

// Cycles that a mode change takes to complete.
`define MODE_SETTLE_CYCLES 4'h3

`endif

// ### inc/clock_mode_pkg.sv
package clock_mode_pkg;

  // Mode encoding shared by the select and status fields.
  typedef enum logic [1:0] {
    self_clocked_mode = 2'h0,
    loop_engaged_internal_mode = 2'h1,
    loop_bypassed_external_mode = 2'h2,
    loop_engaged_external_mode = 2'h3
  } mode_e;

  // Generator state, Gray coded along off, self, unlocked, locked, bypass.
  typedef enum logic [2:0] {
    st_off = 3'h0,
    st_self = 3'h1,
    st_unlocked = 3'h3,
    st_locked = 3'h2,
    st_bypass = 3'h6
  } gen_state_e;

endpackage

// ### logic/sync_two.sv
`timescale 1ns/1ns
// Two flip-flop synchroniser for a level from outside the clock domain.
module sync_two #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_reg;

  // The first stage feeds only the second, never other logic.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_reg <= '0;
      sync_out <= '0;
    end else begin
      stage_reg <= async_in;
      sync_out <= stage_reg;
    end
  end

endmodule

// ### logic/clock_mode_select_control.sv
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
`include "clock_mode_map.svh"
// Functional notes
// RQ1 - Off mode holds output clock static.
// RQ2 - Reset enters self-clocked mode, loop open.
// RQ3 - Internal loop: unlocked state, then locked.
// RQ4 - External loop: unlocked state, then locked.
// RQ5 - Bypass mode uses external clock directly.
// RQ6 - First write reserves input pin if external.
// RQ7 - First write reserves output pin if external; code reserves it only with reference select set.
// RQ8 - Gain select bit seven, write once.
// RQ9 - Range bit six, prescale 64 or 1.
// RQ10 - Reference select bit five, write once.
// RQ11 - Mode select bits four to three encoding.
// RQ12 - Bypass waits for external reference status.
// RQ13 - Off mode leaves mode select unchanged.
// RQ14 - Mode write ignored while previous completes.
// RQ15 - First write 0X blocks later 1X writes.
// RQ16 - Keep-osc bit two rules oscillator in off; code keeps it on in bypass with reference select set.
// RQ17 - Keep-osc ignored when gain and range set.
// RQ18 - Bit one disables loss-of-clock detection.
// RQ19 - Low-power gain-controlled oscillator unless high gain.
// RQ20 - Mode status mirrors mode, may lag.
// RQ21 - Reference status shows selected reference.
// RQ22 - Reset clears mode select and write-once locks.
module clock_mode_select_control (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic stop_request,
  input wire logic stop_enable,
  input wire logic ext_ref_ready,
  input wire logic loop_lock_detect,
  output clock_mode_pkg::gen_state_e gen_state,
  output logic generator_output_run,
  output logic loop_closed,
  output logic use_external_clock,
  output logic ext_pin_as_clock_in,
  output logic ext_pin_as_osc_in,
  output logic osc_out_pin_active,
  output logic osc_enable,
  output logic osc_high_gain,
  output logic [6:0] loop_prescale,
  output logic loss_of_clock_enable,
  output logic [1:0] mode_status,
  output logic reference_status
);
  import clock_mode_pkg::*;

  logic gain_select_reg;
  logic range_reg;
  logic reference_select_reg;
  logic keep_osc_in_off_reg;
  logic loss_of_clock_disable_reg;
  mode_e mode_select_reg;
  logic first_write_done_reg;
  logic pins_reserved_reg;
  logic once_locked_reg;
  logic [3:0] settle_reg;
  logic [3:0] lock_cfg_reg;
  gen_state_e state_reg;
  gen_state_e state_next;
  mode_e mode_next;
  logic ext_ready_sync;
  logic lock_sync;
  logic stop_sync;
  logic ctrl_write;
  logic mode_write_ok;
  logic mode_busy;
  logic in_off;

  // Reference ready, lock detect and stop request cross into the bus clock before anything reads them; stop_enable is read directly.
  sync_two #(
    .WIDTH(3)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({ext_ref_ready, loop_lock_detect, stop_request}),
    .sync_out({ext_ready_sync, lock_sync, stop_sync})
  );

  assign ctrl_write = reg_write && (reg_addr == `CTRL_ONE_ADDR);
  assign mode_busy = (settle_reg != 4'h0);
  mode_e req_mode;
  assign req_mode = mode_e'(reg_wdata[`MODE_SEL_HI:`MODE_SEL_LO]);

  // A mode write takes effect only when no change is pending and the pins
  // allow it; a 1X request after a 0X first write is dropped.
  always_comb begin
    mode_write_ok = ctrl_write && !mode_busy; // RQ14
    if (first_write_done_reg && !pins_reserved_reg && req_mode[1]) begin
      mode_write_ok = 1'b0; // RQ15
    end
  end

  // First write after reset decides whether the external pins are held.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      first_write_done_reg <= 1'b0; // RQ22
      pins_reserved_reg <= 1'b0;
    end else if (ctrl_write && !first_write_done_reg) begin
      first_write_done_reg <= 1'b1;
      pins_reserved_reg <= req_mode[1]; // RQ6 RQ7
    end
  end

  // Write-once bits: only the first control write after reset lands.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gain_select_reg <= 1'b0; // RQ22
      range_reg <= 1'b0;
      reference_select_reg <= 1'b0;
      once_locked_reg <= 1'b0;
    end else if (ctrl_write && !once_locked_reg) begin
      gain_select_reg <= reg_wdata[`GAIN_SEL_BIT]; // RQ8
      range_reg <= reg_wdata[`RANGE_BIT]; // RQ9
      reference_select_reg <= reg_wdata[`REF_SEL_BIT]; // RQ10
      once_locked_reg <= 1'b1;
    end
  end

  // Freely writable control bits.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      keep_osc_in_off_reg <= 1'b0;
      loss_of_clock_disable_reg <= 1'b0;
    end else if (ctrl_write) begin
      keep_osc_in_off_reg <= reg_wdata[`KEEP_OSC_BIT];
      loss_of_clock_disable_reg <= reg_wdata[`LOC_DIS_BIT]; // RQ18
    end
  end

  // Mode select field; entering off never touches it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_select_reg <= self_clocked_mode; // RQ22
    end else if (mode_write_ok) begin
      mode_select_reg <= req_mode; // RQ11 RQ13
    end
  end

  // Settle counter models the time a mode change needs to finish.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_reg <= 4'h0;
    end else if (mode_write_ok && req_mode != mode_select_reg) begin
      settle_reg <= `MODE_SETTLE_CYCLES; // RQ14
    end else if (mode_busy) begin
      settle_reg <= settle_reg - 4'h1;
    end
  end

  // Spare lock configuration register, kept for software scratch use.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_cfg_reg <= `LOCK_CFG_RESET;
    end else if (reg_write && reg_addr == `LOCK_CFG_ADDR) begin
      lock_cfg_reg <= reg_wdata[3:0];
    end
  end

  // Pick the target state for the selected mode.
  always_comb begin
    mode_next = mode_select_reg;
    state_next = state_reg;
    in_off = stop_sync && stop_enable;
    if (in_off) begin
      state_next = st_off; // RQ1
    end else if (!mode_busy) begin
      case (mode_next)
        self_clocked_mode: begin
          state_next = st_self;
        end
        loop_engaged_internal_mode, loop_engaged_external_mode: begin
          if (state_reg == st_unlocked || state_reg == st_locked) begin
            state_next = lock_sync ? st_locked : st_unlocked; // RQ3 RQ4
          end else begin
            state_next = st_unlocked;
          end
        end
        loop_bypassed_external_mode: begin
          // Bypass waits for a running external reference.
          if (ext_ready_sync) begin
            state_next = st_bypass; // RQ12 RQ5
          end
        end
        default: begin
          state_next = st_self;
        end
      endcase
    end
  end

  // Generator state register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= st_self; // RQ2
    end else begin
      state_reg <= state_next;
    end
  end

  // Mode actually running, with the status encoding.
  mode_e run_mode;
  always_comb begin
    case (state_reg)
      st_bypass: run_mode = loop_bypassed_external_mode;
      st_unlocked, st_locked: begin
        run_mode = (mode_select_reg == loop_engaged_external_mode) ?
          loop_engaged_external_mode : loop_engaged_internal_mode;
      end
      st_off: run_mode = mode_select_reg;
      default: run_mode = self_clocked_mode;
    endcase
  end

  // Oscillator enable; in off mode the keep bit decides outside bypass mode, unless both
  // gain and range are set, where the keep bit is ignored; in bypass it stays on with reference select.
  logic osc_on;
  logic keep_active;
  always_comb begin
    keep_active = keep_osc_in_off_reg && !(gain_select_reg && range_reg);
    if (state_reg != st_off) begin
      osc_on = pins_reserved_reg && reference_select_reg &&
        mode_select_reg[1];
    end else if (keep_active) begin
      osc_on = mode_select_reg[1] && reference_select_reg; // RQ16 RQ17
    end else begin
      osc_on = stop_enable && reference_select_reg &&
        mode_select_reg == loop_bypassed_external_mode; // RQ16
    end
  end

  // All outputs come straight from flip-flops.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gen_state <= st_self;
      generator_output_run <= 1'b0;
      loop_closed <= 1'b0;
      use_external_clock <= 1'b0;
      ext_pin_as_clock_in <= 1'b0;
      ext_pin_as_osc_in <= 1'b0;
      osc_out_pin_active <= 1'b0;
      osc_enable <= 1'b0;
      osc_high_gain <= 1'b0;
      loop_prescale <= `PRESCALE_LOW;
      loss_of_clock_enable <= 1'b1;
      mode_status <= 2'h0;
      reference_status <= 1'b0;
    end else begin
      gen_state <= state_reg;
      generator_output_run <= (state_reg != st_off); // RQ1
      loop_closed <= (state_reg == st_unlocked || state_reg == st_locked);
      use_external_clock <= (state_reg == st_bypass); // RQ5
      ext_pin_as_clock_in <= pins_reserved_reg && !reference_select_reg;
      ext_pin_as_osc_in <= pins_reserved_reg && reference_select_reg; // RQ6
      osc_out_pin_active <= pins_reserved_reg && reference_select_reg; // RQ7
      osc_enable <= osc_on;
      osc_high_gain <= gain_select_reg; // RQ19
      loop_prescale <= range_reg ? `PRESCALE_HIGH : `PRESCALE_LOW; // RQ9
      loss_of_clock_enable <= !loss_of_clock_disable_reg; // RQ18
      mode_status <= run_mode; // RQ20
      reference_status <= reference_select_reg; // RQ21
    end
  end

  // Read port: data stand in the cycle after the read strobe.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        `CTRL_ONE_ADDR: reg_rdata <= {gain_select_reg, range_reg,
          reference_select_reg, mode_select_reg, keep_osc_in_off_reg,
          loss_of_clock_disable_reg, 1'b0};
        `STATUS_ADDR: reg_rdata <= {mode_status, reference_status, 1'b0,
          state_reg == st_locked, 3'h0};
        `LOCK_CFG_ADDR: reg_rdata <= {4'h0, lock_cfg_reg};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

// ### verif/clock_source_model.sv
`timescale 1ns/1ns
// Outside reference source plus the loop's lock detector, with start-up delay.
module clock_source_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ref_on,
  input wire logic lock_on,
  input wire logic [7:0] delay,
  output logic ext_ref_ready,
  output logic loop_lock_detect
);
  logic [7:0] ref_cnt;
  logic [7:0] lock_cnt;
  // A source with delay zero is ready at once; a larger delay makes it slow.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_cnt <= 8'h00;
      lock_cnt <= 8'h00;
    end else begin
      ref_cnt <= ref_on ? ref_cnt + {7'h00, ref_cnt != delay} : 8'h00;
      lock_cnt <= lock_on ? lock_cnt + {7'h00, lock_cnt != delay} : 8'h00;
    end
  end
  // Status levels go high only once the delay has run out.
  assign ext_ref_ready = ref_on && ref_cnt == delay;
  assign loop_lock_detect = lock_on && lock_cnt == delay;
endmodule

// ### verif/clock_mode_select_control_assertions.sv
`timescale 1ns/1ns
module clock_mode_checker
  import clock_mode_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic stop_request,
  input wire logic stop_enable,
  input wire logic ext_ref_ready,
  input wire clock_mode_pkg::gen_state_e gen_state,
  input wire logic generator_output_run,
  input wire logic use_external_clock,
  input wire logic ext_pin_as_clock_in,
  input wire logic ext_pin_as_osc_in,
  input wire logic osc_out_pin_active,
  input wire logic osc_high_gain,
  input wire logic loss_of_clock_enable,
  input wire logic [1:0] mode_status,
  input wire logic reference_status
);
  logic first_done;
  logic first_low;
  logic ready_seen;
  logic [2:0] age;
  wire ctrl_wr = reg_write && reg_addr == 4'h0;
  // Track the first control write; its age tells when locks must hold.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      first_done <= 1'b0;
      first_low <= 1'b0;
      age <= 3'h0;
    end else begin
      if (ctrl_wr && !first_done) begin
        first_done <= 1'b1;
        first_low <= !reg_wdata[4];
      end
      if (first_done && age != 3'h7) begin
        age <= age + 3'h1;
      end
    end
  end
  // Sticky, because the design may only bypass after seeing the reference.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_seen <= 1'b0;
    end else if (ext_ref_ready) begin
      ready_seen <= 1'b1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_off_req; stop_request && stop_enable; endsequence
  sequence s_was_unlocked; $past(gen_state) == st_unlocked; endsequence
  property p_off; s_off_req [*8] |-> !generator_output_run; endproperty
  property p_rst; $rose(rst_n) |-> gen_state == st_self && mode_status == 2'h0;
  endproperty
  property p_lock;
    $rose(gen_state == st_locked) |-> s_was_unlocked;
  endproperty
  property p_byp; use_external_clock |-> ready_seen; endproperty
  property p_gain; age == 3'h7 |-> $stable(osc_high_gain); endproperty
  property p_reference_select; age == 3'h7 |-> $stable(reference_status); endproperty
  property p_pins; first_low |-> !(ext_pin_as_clock_in || ext_pin_as_osc_in
    || osc_out_pin_active); endproperty
  property p_blk; first_low |-> !mode_status[1]; endproperty
  property p_loc;
    ctrl_wr |-> ##2 loss_of_clock_enable == !$past(reg_wdata[1], 2);
  endproperty
  a_off: assert property (p_off) else $error("output runs in off");
  a_rst: assert property (p_rst) else $error("not self after reset");
  a_lock: assert property (p_lock) else $error("lock skipped unlocked");
  a_byp: assert property (p_byp) else $error("bypass before ready");
  a_gain: assert property (p_gain) else $error("gain changed");
  a_reference_select: assert property (p_reference_select) else $error("reference moved");
  a_pins: assert property (p_pins) else $error("pins reserved");
  a_blk: assert property (p_blk) else $error("external mode taken");
  a_loc: assert property (p_loc) else $error("loss detect wrong");
endmodule
bind clock_mode_select_control clock_mode_checker u_chk (.clk(clk),
  .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .stop_request(stop_request),
  .stop_enable(stop_enable), .ext_ref_ready(ext_ref_ready),
  .gen_state(gen_state), .generator_output_run(generator_output_run),
  .use_external_clock(use_external_clock),
  .ext_pin_as_clock_in(ext_pin_as_clock_in),
  .ext_pin_as_osc_in(ext_pin_as_osc_in),
  .osc_out_pin_active(osc_out_pin_active), .osc_high_gain(osc_high_gain),
  .loss_of_clock_enable(loss_of_clock_enable), .mode_status(mode_status),
  .reference_status(reference_status));

// ### verif/clock_mode_select_control_tb_top.sv
`timescale 1ns/1ns
module clock_mode_select_control_tb_top;
  import clock_mode_pkg::*;
  logic clk, rst_n, reg_write, reg_read, stop_request, stop_enable;
  logic ref_on, lock_on, ext_ref_ready, loop_lock_detect;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, delay, d, d0, m_ctrl;
  gen_state_e gen_state;
  logic generator_output_run, loop_closed, use_external_clock, osc_enable;
  logic ext_pin_as_clock_in, ext_pin_as_osc_in, osc_out_pin_active;
  logic osc_high_gain, loss_of_clock_enable, reference_status;
  logic [6:0] loop_prescale;
  logic [1:0] mode_status;
  logic [31:0] seed;
  int n_errors, compares, cyc, m_first, m_low;
  time last;
  clock_mode_select_control uut (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .stop_request(stop_request),
    .stop_enable(stop_enable), .ext_ref_ready(ext_ref_ready),
    .loop_lock_detect(loop_lock_detect), .gen_state(gen_state),
    .generator_output_run(generator_output_run), .loop_closed(loop_closed),
    .use_external_clock(use_external_clock),
    .ext_pin_as_clock_in(ext_pin_as_clock_in),
    .ext_pin_as_osc_in(ext_pin_as_osc_in),
    .osc_out_pin_active(osc_out_pin_active), .osc_enable(osc_enable),
    .osc_high_gain(osc_high_gain), .loop_prescale(loop_prescale),
    .loss_of_clock_enable(loss_of_clock_enable), .mode_status(mode_status),
    .reference_status(reference_status));
  clock_source_model src (.clk(clk), .rst_n(rst_n), .ref_on(ref_on),
    .lock_on(lock_on), .delay(delay), .ext_ref_ready(ext_ref_ready),
    .loop_lock_detect(loop_lock_detect));
  // Free-running 250 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // A hang is cut off well beyond the few hundred cycles the run needs.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      final_report;
    end
  end
  task automatic final_report;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // Reference model: locks taken by the first write, settle window of 3.
  task automatic wr(input logic [7:0] v);
    @(posedge clk);
    reg_addr <= 4'h0;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    if (m_first == 0) begin
      m_first = 1;
      m_low = !v[4];
      m_ctrl = v;
      last = $time;
    end else begin
      m_ctrl[2:1] = v[2:1];
      if ($time - last > 12 && !(m_low && v[4]) && v[4:3] != m_ctrl[4:3]) begin
        m_ctrl[4:3] = v[4:3];
        last = $time;
      end
    end
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    // Data stand only in the cycle after the strobe; take them at its end.
    @(posedge clk);
    v = reg_rdata;
  endtask
  task automatic wait_st(input gen_state_e s);
    for (int i = 0; i < 200 && gen_state !== s; i++) @(posedge clk);
    chk({5'h00, gen_state}, {5'h00, s});
  endtask
  task automatic do_reset;
    rst_n <= 1'b0;
    ref_on <= 1'b0;
    lock_on <= 1'b0;
    m_first = 0;
    m_ctrl = 8'h00;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  initial begin
    {rst_n, reg_write, reg_read, stop_request, stop_enable} = 5'h00;
    {ref_on, lock_on, reg_addr, reg_wdata, delay} = 22'h0;
    seed = 32'h37;
    do_reset;
    rd(4'h0, d); chk(d, 8'h00);
    chk({5'h00, gen_state}, {5'h00, st_self});
    d0 = rnd();
    wr((d0 & 8'he6) | 8'h08);
    wr((~d0 & 8'he6) | 8'h18);
    repeat (3) @(posedge clk);
    rd(4'h0, d); chk(d, m_ctrl);
    chk(8'({ext_pin_as_clock_in, ext_pin_as_osc_in}), 8'h00);
    chk(8'(loss_of_clock_enable), 8'(!m_ctrl[1]));
    wait_st(st_unlocked);
    delay <= rnd() & 8'h1f;
    lock_on <= 1'b1;
    wait_st(st_locked);
    rd(4'h1, d); chk(d & 8'hc8, 8'h48);
    wr(8'h00);
    wr(8'h08);
    repeat (10) @(posedge clk);
    rd(4'h0, d); chk(d, m_ctrl);
    chk(8'(mode_status), 8'h00);
    wr(8'h0c);
    stop_request <= 1'b1;
    stop_enable <= 1'b1;
    wait_st(st_off);
    chk(8'(generator_output_run), 8'h00);
    chk(8'(osc_enable), 8'h00);
    rd(4'h0, d); chk(d, m_ctrl);
    // Hold the stop request long enough for the off assertion to engage.
    repeat (4) @(posedge clk);
    stop_request <= 1'b0;
    repeat (10) @(posedge clk);
    chk(8'(generator_output_run), 8'h01);
    for (int k = 0; k < 2; k++) begin
      do_reset;
      d0 = (rnd() & 8'hc6) | 8'h10 | (k[0] ? 8'h20 : 8'h00);
      wr(d0);
      repeat (20) @(posedge clk);
      chk(8'(use_external_clock), 8'h00);
      chk(8'({ext_pin_as_clock_in, ext_pin_as_osc_in}),
        k ? 8'h01 : 8'h02);
      chk(8'(osc_out_pin_active), 8'(k[0]));
      chk(8'(osc_enable), 8'(k[0]));
      chk(8'(reference_status), 8'(k[0]));
      chk(8'(osc_high_gain), 8'(d0[7]));
      chk(8'(loop_prescale), d0[6] ? 8'h01 : 8'h40);
      delay <= rnd() & 8'h3f;
      ref_on <= 1'b1;
      wait_st(st_bypass);
      chk(8'({use_external_clock, loop_closed}), 8'h02);
      wr(d0 | 8'h08);
      wait_st(st_unlocked);
      lock_on <= 1'b1;
      wait_st(st_locked);
      rd(4'h1, d); chk(d & 8'he8, k ? 8'he8 : 8'hc8);
      // Off from a locked external mode: the keep bit rules the oscillator.
      stop_request <= 1'b1;
      wait_st(st_off);
      chk(8'(osc_enable), 8'(k[0] && d0[2] && !(d0[7] && d0[6])));
      stop_request <= 1'b0;
    end
    final_report;
  end
endmodule
